//--- core/fdm_pkg.sv
package fdm_pkg;
	// Error codes presented on the serial output registers
	localparam logic [15:0] FDM_CODE_NONE     = 16'h0000;
	localparam logic [15:0] FDM_CODE_RAM_PAR  = 16'hC001;
	localparam logic [15:0] FDM_CODE_CFG_PAR  = 16'hC002;
	localparam logic [15:0] FDM_CODE_NVM_MB   = 16'hC004;
	localparam logic [15:0] FDM_CODE_WDG      = 16'hC008;
	localparam logic [15:0] FDM_CODE_SENS     = 16'hC010;
	localparam logic [15:0] FDM_CODE_NVM_SIG  = 16'hC0AA;
	localparam logic [15:0] FDM_CODE_PROG_SIG = 16'hC0CC;
	localparam logic [15:0] FDM_CODE_ICC      = 16'hC0FF;
	// Limit register value that switches the aging check off
	localparam logic [15:0] FDM_AGING_OFF     = 16'hFF00;

	localparam int FDM_CLK_HZ          = 40_000_000;
	localparam int FDM_OSC_TIMEOUT_US  = 200;
	// Longest time: round down
	localparam int FDM_OSC_TIMEOUT_CYC = (FDM_OSC_TIMEOUT_US * (FDM_CLK_HZ / 1000)) / 1000;
	localparam int FDM_STARTUP_CLKS    = 69632;
	localparam int FDM_CYCLE_WDG_MULT  = 2;
	localparam int FDM_TMP_DM_THRESH   = 2;

	typedef struct packed {
		logic prog_sig_en;
		logic sensor_chk_en;
		logic temp_chk_en;
		logic legacy_rev;
		logic reset_on_fatal;
	} fdm_cfg_s;

	typedef struct packed {
		logic [15:0] limit_ctl;
		logic [15:0] low;
		logic [15:0] high;
	} fdm_aging_s;

	typedef enum {FDM_PH_STARTUP, FDM_PH_RUN} fdm_phase_e;
endpackage : fdm_pkg

//--- core/fdm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fdm_monitor #(
	parameter int WDG_W        = 20,
	parameter int STARTUP_CLKS = fdm_pkg::FDM_STARTUP_CLKS,
	parameter int OSC_CYC      = fdm_pkg::FDM_OSC_TIMEOUT_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire fdm_pkg::fdm_cfg_s cfg,
	input  wire fdm_pkg::fdm_aging_s aging,
	input  wire logic              supply_loss_detect,
	input  wire logic              startup_done,
	input  wire logic              reload_and_restart_command,
	input  wire logic              meas_cycle_start,
	input  wire logic [15:0]       conv_cycle_clks,
	input  wire logic              osc_tick,
	input  wire logic              ram_rd_valid,
	input  wire logic              ram_parity_err,
	input  wire logic              cfg_parity_err,
	input  wire logic              nvm_multibit_err,
	input  wire logic              nvm_load_active,
	input  wire logic              nvm_sig_fail,
	input  wire logic              prog_sig_fail,
	input  wire logic              icc_fail,
	input  wire logic              alu_fail,
	input  wire logic              sens_conn_fail,
	input  wire logic              sens_short_fail,
	input  wire logic              temp_valid,
	input  wire logic [15:0]       temp_raw,
	input  wire logic [4:0]        temp_res,
	input  wire logic              cmv_valid,
	input  wire logic [15:0]       cmv_value,
	output logic [15:0]            error_code,
	output logic                   diagnostic_state,
	output logic                   lower_diagnostic_range,
	output logic                   serial_out_load,
	output logic                   reset_request,
	output logic                   startup_phase
);
	import fdm_pkg::*;

	localparam logic [WDG_W-1:0] STARTUP_LIM = WDG_W'(STARTUP_CLKS);
	localparam logic [13:0]      OSC_LIM     = 14'(OSC_CYC);
	localparam logic [1:0]       TMP_MAX     = 2'(FDM_TMP_DM_THRESH);

	fdm_phase_e       phase_r;
	logic [WDG_W-1:0] wdg_cnt_r;
	logic             wdg_fired_r;
	logic [13:0]      osc_cnt_r;
	logic             osc_fault_r;
	logic             sens_seen_r;
	logic [1:0]       tmp_cnt_r;
	logic             tmp_dm_r;
	logic             tmp_sens_r;
	logic [15:0]      perm_code_r;
	logic             perm_dm_r;
	logic             dm_prev_r;
	logic [15:0]      error_code_r;
	logic             reset_req_r;

	wire              clr = supply_loss_detect;
	wire              in_start = (phase_r == FDM_PH_STARTUP);
	wire [WDG_W-1:0]  cyc_lim = WDG_W'({conv_cycle_clks, 1'b0});
	wire              wdg_expire = !wdg_fired_r &&
		(in_start ? (wdg_cnt_r >= STARTUP_LIM)
		          : (wdg_cnt_r > cyc_lim));

	// Temperature full scale is 2^res - 1, computed one bit wider
	wire [16:0]       temp_max = (17'h00001 << temp_res) - 17'h00001;
	wire              temp_bad = temp_valid && cfg.temp_chk_en &&
		(temp_raw == 16'h0000 || {1'b0, temp_raw} >= temp_max);
	wire              aging_bad = cmv_valid && aging.limit_ctl != FDM_AGING_OFF &&
		(cmv_value < aging.low || cmv_value > aging.high);
	wire              conn_bad = cfg.sensor_chk_en &&
		(sens_conn_fail || sens_short_fail);
	wire              sens_now = temp_bad || aging_bad || conn_bad;
	wire              cycle_fail = sens_seen_r || sens_now || osc_fault_r;
	wire              cycle_sens = sens_seen_r || sens_now;

	// Fatal checks have no enable: armed after reset; the watchdog fires once until reload or supply loss
	wire ram_ev  = ram_rd_valid && ram_parity_err;
	wire cfg_ev  = cfg_parity_err;
	wire fatal   = ram_ev || cfg_ev || alu_fail || wdg_expire;
	wire mb_ev   = in_start && nvm_multibit_err;
	wire sig_ev  = nvm_load_active && nvm_sig_fail;
	wire prog_ev = in_start && cfg.prog_sig_en && prog_sig_fail;
	wire icc_ev  = cfg.legacy_rev && icc_fail;

	wire [15:0] new_code =
		(ram_ev   ? FDM_CODE_RAM_PAR  : FDM_CODE_NONE) |
		(cfg_ev   ? FDM_CODE_CFG_PAR  : FDM_CODE_NONE) |
		(mb_ev    ? FDM_CODE_NVM_MB   : FDM_CODE_NONE) |
		(alu_fail ? FDM_CODE_SENS     : FDM_CODE_NONE) |
		(sig_ev   ? FDM_CODE_NVM_SIG  : FDM_CODE_NONE) |
		(prog_ev  ? FDM_CODE_PROG_SIG : FDM_CODE_NONE) |
		(icc_ev   ? FDM_CODE_ICC      : FDM_CODE_NONE);
	wire        perm_ev = fatal || mb_ev || sig_ev || prog_ev || icc_ev;
	wire [15:0] perm_code_nxt = wdg_expire ? (FDM_CODE_WDG | new_code)
	                                       : (perm_code_r | new_code);

	// Temporary mode counter: up on a failing cycle, down on a clean one
	wire        eval = meas_cycle_start;
	wire [1:0]  tmp_cnt_nxt = !eval ? tmp_cnt_r :
		cycle_fail ? ((tmp_cnt_r == TMP_MAX) ? tmp_cnt_r : tmp_cnt_r + 2'h1) :
		((tmp_cnt_r == 2'h0) ? tmp_cnt_r : tmp_cnt_r - 2'h1);
	wire        tmp_dm_nxt = (tmp_cnt_nxt == TMP_MAX) ? 1'b1 :
		(tmp_cnt_nxt == 2'h0) ? 1'b0 : tmp_dm_r;
	wire        tmp_sens_nxt = !tmp_dm_nxt ? 1'b0 :
		(eval && cycle_sens) ? 1'b1 : tmp_sens_r;
	// Oscillator fault enters temporary mode without a code
	wire [15:0] tmp_code = tmp_sens_nxt ? FDM_CODE_SENS : FDM_CODE_NONE;
	wire        perm_dm_nxt = perm_dm_r || perm_ev;
	wire        dm_now = perm_dm_r || tmp_dm_r;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_r <= FDM_PH_STARTUP;
		end else if (clr || reload_and_restart_command) begin
			phase_r <= FDM_PH_STARTUP;
		end else begin
			case (phase_r)
				FDM_PH_STARTUP: if (startup_done) phase_r <= FDM_PH_RUN;
				FDM_PH_RUN:     phase_r <= FDM_PH_RUN;
				default:        phase_r <= FDM_PH_STARTUP;
			endcase
		end
	end

	// Watchdog restarts with each cycle and on reload
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wdg_cnt_r   <= '0;
			wdg_fired_r <= 1'b0;
		end else if (clr || reload_and_restart_command) begin
			wdg_cnt_r   <= '0;
			wdg_fired_r <= 1'b0;
		end else begin
			if ((!in_start && meas_cycle_start) || (in_start && startup_done))
				wdg_cnt_r <= '0;
			else if (wdg_cnt_r != '1)
				wdg_cnt_r <= wdg_cnt_r + 1'b1;
			if (wdg_expire)
				wdg_fired_r <= 1'b1;
		end
	end

	// Oscillator monitor: ticks of the checked oscillator must keep coming
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			osc_cnt_r   <= '0;
			osc_fault_r <= 1'b0;
		end else if (clr || osc_tick) begin
			osc_cnt_r   <= '0;
			osc_fault_r <= 1'b0;
		end else if (osc_cnt_r >= OSC_LIM - 14'h0001) begin
			osc_fault_r <= 1'b1;
		end else begin
			osc_cnt_r <= osc_cnt_r + 14'h0001;
		end
	end

	// Sensor results gathered over one cycle; the clear at cycle start wins over a new fail
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sens_seen_r <= 1'b0;
		end else if (clr) begin
			sens_seen_r <= 1'b0;
		end else if (eval) begin
			sens_seen_r <= 1'b0;
		end else if (sens_now) begin
			sens_seen_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tmp_cnt_r  <= '0;
			tmp_dm_r   <= 1'b0;
			tmp_sens_r <= 1'b0;
		end else if (clr) begin
			tmp_cnt_r  <= '0;
			tmp_dm_r   <= 1'b0;
			tmp_sens_r <= 1'b0;
		end else begin
			tmp_cnt_r  <= tmp_cnt_nxt;
			tmp_dm_r   <= tmp_dm_nxt;
			tmp_sens_r <= tmp_sens_nxt;
		end
	end

	// Permanent codes stay until reset or supply loss; only the watchdog overwrites them
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			perm_code_r  <= FDM_CODE_NONE;
			perm_dm_r    <= 1'b0;
			dm_prev_r    <= 1'b0;
			error_code_r <= FDM_CODE_NONE;
			reset_req_r  <= 1'b0;
		end else if (clr) begin
			perm_code_r  <= FDM_CODE_NONE;
			perm_dm_r    <= 1'b0;
			dm_prev_r    <= 1'b0;
			error_code_r <= FDM_CODE_NONE;
			reset_req_r  <= 1'b0;
		end else begin
			perm_code_r  <= perm_code_nxt;
			perm_dm_r    <= perm_dm_nxt;
			// Last cycle's mode, so the load strobe marks the entry edge
			dm_prev_r    <= dm_now;
			error_code_r <= perm_code_nxt | tmp_code;
			if (fatal && cfg.reset_on_fatal)
				reset_req_r <= 1'b1;
		end
	end

	assign error_code             = error_code_r;
	assign diagnostic_state       = dm_now;
	assign lower_diagnostic_range = dm_now;
	assign serial_out_load        = dm_now && !dm_prev_r;
	assign reset_request          = reset_req_r;
	assign startup_phase          = in_start;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn || supply_loss_detect);

	a_ram_parity_code: assert property (
		ram_rd_valid && ram_parity_err |=> error_code[0] && diagnostic_state)
		else $error("ram parity not reported");
	a_cfg_parity_code: assert property (
		cfg_parity_err |=> error_code[1] && diagnostic_state)
		else $error("config parity not reported");
	a_nvm_mb_code: assert property (
		in_start && nvm_multibit_err |=> error_code[2] && diagnostic_state)
		else $error("nvm multibit not reported");
	a_nvm_sig_code: assert property (
		nvm_load_active && nvm_sig_fail |=>
		(error_code & FDM_CODE_NVM_SIG) == FDM_CODE_NVM_SIG && diagnostic_state)
		else $error("nvm signature not reported");
	a_prog_sig_code: assert property (
		in_start && cfg.prog_sig_en && prog_sig_fail |=>
		(error_code & FDM_CODE_PROG_SIG) == FDM_CODE_PROG_SIG && diagnostic_state)
		else $error("program signature not reported");
	a_icc_code: assert property (
		cfg.legacy_rev && icc_fail |=> error_code[7:0] == 8'hFF && diagnostic_state)
		else $error("inconsistent config not reported");
	a_alu_code: assert property (
		alu_fail |=> error_code[4] && diagnostic_state)
		else $error("arithmetic fail not reported");
	// Reload restarts the watchdog, so it is left out of the antecedent
	a_wdg_start_lim: assert property (
		in_start && !wdg_fired_r && wdg_cnt_r == STARTUP_LIM && !startup_done &&
		!reload_and_restart_command |=> wdg_fired_r && error_code[3])
		else $error("startup watchdog missed");
	a_wdg_cycle_lim: assert property (
		!in_start && !wdg_fired_r && wdg_cnt_r > cyc_lim && !reload_and_restart_command
		|=> wdg_fired_r && error_code[3] && diagnostic_state)
		else $error("cycle watchdog missed");
	a_wdg_replaces: assert property (
		wdg_expire && !new_code[7] |=> perm_code_r == (FDM_CODE_WDG | $past(new_code)))
		else $error("watchdog code not replacing");
	a_aging_disabled: assert property (
		aging.limit_ctl == FDM_AGING_OFF |-> !aging_bad)
		else $error("aging check not disabled");
	a_tmp_dm_entry: assert property (
		tmp_cnt_r == 2'h1 && eval && cycle_fail |=> tmp_dm_r)
		else $error("temporary mode not entered");
	a_tmp_dm_exit: assert property (
		tmp_cnt_r == 2'h1 && eval && !cycle_fail |=> !tmp_dm_r)
		else $error("temporary mode not left");
	a_osc_timeout: assert property (
		!osc_tick [*8] ##1 (osc_cnt_r == OSC_LIM - 14'h0001 && !osc_tick) |=> osc_fault_r)
		else $error("oscillator fault late");
	a_fatal_reset: assert property (
		fatal && cfg.reset_on_fatal |=> reset_request [*2])
		else $error("reset request missing");
	a_reset_sticky: assert property (
		reset_request |=> reset_request)
		else $error("reset request dropped");
	a_ldr_on_dm: assert property (
		$rose(diagnostic_state) |-> serial_out_load && lower_diagnostic_range)
		else $error("diagnostic entry not signalled");
	a_load_pulse: assert property (
		serial_out_load |=> !serial_out_load)
		else $error("serial load longer than one cycle");
	a_perm_dm_holds: assert property (
		perm_dm_r |=> diagnostic_state)
		else $error("permanent diagnostic mode left");
	// Own disable: the default one would hide the supply loss itself
	a_supply_clear: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		supply_loss_detect |=> error_code == FDM_CODE_NONE && !diagnostic_state && !reset_request)
		else $error("supply loss did not clear");

	c_wdg_fire: cover property (wdg_expire);
	c_tmp_dm: cover property ($rose(tmp_dm_r));
	c_tmp_exit: cover property ($fell(tmp_dm_r));
	c_prog_sig: cover property (prog_ev ##1 error_code == FDM_CODE_PROG_SIG);
	c_osc_tmp: cover property (osc_fault_r && eval);
endmodule : fdm_monitor
`default_nettype wire

//--- bench/fdm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fdm_host_model (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        serial_out_load,
	input  wire logic [15:0] error_code,
	output logic [15:0]      host_code
);
	// Host sees only what was latched into the serial output registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			host_code <= 16'h0000;
		end else if (serial_out_load) begin
			host_code <= error_code;
		end
	end
endmodule : fdm_host_model
`default_nettype wire

//--- bench/fdm_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fdm_monitor_tb;
	import fdm_pkg::*;
	localparam int SCLK = 100;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	fdm_cfg_s    cfg = '0;
	fdm_aging_s  aging = '0;
	logic        supply_loss_detect = 0, startup_done = 0, reload_and_restart_command = 0;
	logic        meas_cycle_start = 0, osc_tick = 0, ram_rd_valid = 0, ram_parity_err = 0;
	logic        cfg_parity_err = 0, nvm_multibit_err = 0, nvm_load_active = 0, nvm_sig_fail = 0;
	logic        prog_sig_fail = 0, icc_fail = 0, alu_fail = 0, sens_conn_fail = 0;
	logic        sens_short_fail = 0, temp_valid = 0, cmv_valid = 0, osc_run = 1;
	logic [15:0] conv_cycle_clks = 16'h0032, temp_raw = 16'h0100, cmv_value = 16'h0000;
	logic [4:0]  temp_res = 5'h0E;
	logic [15:0] error_code, host_code;
	logic        diagnostic_state, lower_diagnostic_range, serial_out_load;
	logic        reset_request, startup_phase;
	int          fails = 0, n_compared = 0, cyc = 0;

	fdm_monitor #(.STARTUP_CLKS(SCLK), .OSC_CYC(20)) fdm_monitor_inst (.clk_sys, .resetn, .cfg,
		.aging, .supply_loss_detect, .startup_done, .reload_and_restart_command,
		.meas_cycle_start, .conv_cycle_clks, .osc_tick, .ram_rd_valid, .ram_parity_err,
		.cfg_parity_err, .nvm_multibit_err, .nvm_load_active, .nvm_sig_fail, .prog_sig_fail,
		.icc_fail, .alu_fail, .sens_conn_fail, .sens_short_fail, .temp_valid, .temp_raw,
		.temp_res, .cmv_valid, .cmv_value, .error_code, .diagnostic_state,
		.lower_diagnostic_range, .serial_out_load, .reset_request, .startup_phase);
	fdm_host_model fdm_host_model_inst (.clk_sys, .resetn, .serial_out_load, .error_code,
		.host_code);

	always #12.5 clk_sys = ~clk_sys;
	// Healthy oscillator keeps the temporary mode out of the other tests
	always @(posedge clk_sys) osc_tick <= #2 osc_run & ~osc_tick;
	always @(posedge clk_sys) cyc <= resetn ? cyc + 1 : 0;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : tick
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic do_reset(input fdm_cfg_s c);
		cfg = c;
		resetn = 1'b0;
		tick(2);
		resetn = 1'b1;
	endtask : do_reset
	task automatic end_test(input string name);
		$display("test %s done: %0d compared, %0d wrong", name, n_compared, fails);
	endtask : end_test
	task automatic mcycle(input int n);
		meas_cycle_start = 1'b1;
		tick(1);
		meas_cycle_start = 1'b0;
		tick(n - 1);
	endtask : mcycle
	task automatic run_phase(input logic [15:0] conv);
		conv_cycle_clks = conv;
		startup_done = 1'b1;
		tick(1);
		startup_done = 1'b0;
	endtask : run_phase
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict

	initial begin
		#100us;
		fails++;
		give_verdict();
	end

	initial begin
		do_reset(5'b00001);
		check({error_code[14:0], startup_phase}, 16'h0001);
		{ram_rd_valid, ram_parity_err} = 2'b11;
		tick(1);
		{ram_rd_valid, ram_parity_err} = 2'b00;
		check(error_code, FDM_CODE_RAM_PAR);
		check(16'({diagnostic_state, lower_diagnostic_range, serial_out_load, reset_request}),
			16'h000F);
		tick(1);
		check(16'(serial_out_load), 16'h0000);
		check(host_code, FDM_CODE_RAM_PAR);
		supply_loss_detect = 1'b1;
		tick(1);
		supply_loss_detect = 1'b0;
		check(16'({error_code, diagnostic_state, reset_request}), 16'h0000);
		end_test("ram_parity");
		do_reset(5'b00000);
		{cfg_parity_err, alu_fail, nvm_multibit_err} = 3'b111;
		tick(1);
		{cfg_parity_err, alu_fail, nvm_multibit_err} = 3'b000;
		check(error_code, FDM_CODE_CFG_PAR | FDM_CODE_SENS | FDM_CODE_NVM_MB);
		check(16'({diagnostic_state, reset_request}), 16'h0002);
		end_test("or_codes");
		do_reset(5'b00000);
		{prog_sig_fail, icc_fail, nvm_sig_fail} = 3'b111;
		tick(1);
		{prog_sig_fail, icc_fail, nvm_sig_fail} = 3'b000;
		tick(1);
		check(error_code, FDM_CODE_NONE);
		cfg.prog_sig_en = 1'b1;
		{prog_sig_fail, nvm_load_active, nvm_sig_fail} = 3'b111;
		tick(1);
		{prog_sig_fail, nvm_load_active, nvm_sig_fail} = 3'b000;
		check(error_code, FDM_CODE_PROG_SIG | FDM_CODE_NVM_SIG);
		while (error_code === (FDM_CODE_PROG_SIG | FDM_CODE_NVM_SIG) && cyc < 2 * SCLK) tick(1);
		check(error_code, FDM_CODE_WDG);
		check(16'(cyc inside {[SCLK - 1 : SCLK + 2]}), 16'h0001);
		end_test("startup_watchdog");
		do_reset(5'b00010);
		icc_fail = 1'b1;
		tick(1);
		icc_fail = 1'b0;
		check(error_code, FDM_CODE_ICC);
		run_phase(16'h000A);
		check(16'(startup_phase), 16'h0000);
		repeat (4) mcycle(18);
		mcycle(19);
		check(error_code, FDM_CODE_ICC);
		tick(6);
		check(error_code, FDM_CODE_WDG);
		end_test("cycle_watchdog");
		do_reset(5'b01100);
		run_phase(16'h0032);
		aging = {FDM_AGING_OFF, 16'h1000, 16'h2000};
		mcycle(8);
		{cmv_valid, cmv_value} = {1'b1, 16'hFFFF};
		tick(1);
		cmv_valid = 1'b0;
		mcycle(8);
		sens_conn_fail = 1'b1;
		tick(1);
		sens_conn_fail = 1'b0;
		mcycle(8);
		check(16'(diagnostic_state), 16'h0000);
		{temp_valid, temp_raw} = {1'b1, 16'h3FFF};
		tick(1);
		temp_valid = 1'b0;
		mcycle(8);
		check(16'({diagnostic_state, lower_diagnostic_range}), 16'h0003);
		check(error_code, FDM_CODE_SENS);
		mcycle(8);
		check(16'(diagnostic_state), 16'h0001);
		mcycle(8);
		check(16'({error_code, diagnostic_state}), 16'h0000);
		end_test("temporary_mode");
		osc_run = 1'b0;
		tick(25);
		mcycle(8);
		mcycle(8);
		check(16'(diagnostic_state), 16'h0001);
		check(error_code, FDM_CODE_NONE);
		osc_run = 1'b1;
		end_test("oscillator_fault");
		give_verdict();
	end
endmodule : fdm_monitor_tb
`default_nettype wire
